// ===== common/lie_defs.svh
// Constants for the character display instruction executor
`ifndef LIE_DEFS_SVH
`define LIE_DEFS_SVH

`define LIE_OFF_CMD         5'h00
`define LIE_OFF_DATA        5'h04
`define LIE_OFF_STATUS      5'h08
`define LIE_OFF_CONFIG      5'h0c
`define LIE_OFF_RDBUF       5'h10

`define LIE_CYC_STD         8'd3
`define LIE_CYC_CLEAR       8'd165
`define LIE_BLANK_CODE      8'h20
`define LIE_TEXT_DEPTH      128
`define LIE_PATTERN_BASE    7'h40
`define LIE_AXI_OKAY        2'b00
`define LIE_AXI_SLVERR      2'b10

`endif

// ===== common/lie_pkg.sv
// Types shared by the instruction executor
package lie_pkg;
	typedef enum logic [2:0] {
		LIE_IDLE  = 3'b001,
		LIE_BUSY  = 3'b010,
		LIE_CLEAR = 3'b100
	} lie_state_t;
endpackage

// ===== logic/lie_executor.sv
// Instruction decoder and executor with an AXI4-Lite register front end
`timescale 1ns/1ps
`default_nettype none
`include "lie_defs.svh"

// How it works
// - while busy, only status read executes
// - busy held through execution; others discarded
// - serial control byte: continuation, select, zeros; there is no serial port here, and the AXI offset picks command or data
// - serial direction comes from address bit; here the separate AXI read and write channels set it
// - function set stores width, lines, set
// - status read returns busy and counter; NOP
// - data access to text or pattern RAM
// - clear fills blanks, zeros counter, increments
// - home zeros counter and shift only
// - entry mode direction steps counter
// - cursor and blink off in pattern RAM
// - text write with shift bit shifts display
// - display off means partial power-down
// - instructions still run while display off
// - shift command moves cursor or display
// - pattern address keeps bit six
// - extended mirroring and icon commands
// - column and row mirroring outputs
// - icon modes; split ignored in two-line
// - read buffer reloads on address, read
// - four-bit width moves two nibbles
module lie_executor
	import lie_pkg::*;
(
	input  wire logic        clk,             // 10 MHz clock
	input  wire logic        reset,           // Synchronous, active high
	input  wire logic        clkEn,           // Freezes all state when low
	input  wire logic [4:0]  s_axi_awaddr,    // Write address
	input  wire logic        s_axi_awvalid,   // Write address valid
	output logic             s_axi_awready,   // Write address ready
	input  wire logic [31:0] s_axi_wdata,     // Write data
	input  wire logic [3:0]  s_axi_wstrb,     // Write strobes
	input  wire logic        s_axi_wvalid,    // Write data valid
	output logic             s_axi_wready,    // Write data ready
	output logic [1:0]       s_axi_bresp,     // Write response
	output logic             s_axi_bvalid,    // Write response valid
	input  wire logic        s_axi_bready,    // Write response ready
	input  wire logic [4:0]  s_axi_araddr,    // Read address
	input  wire logic        s_axi_arvalid,   // Read address valid
	output logic             s_axi_arready,   // Read address ready
	output logic [31:0]      s_axi_rdata,     // Read data
	output logic [1:0]       s_axi_rresp,     // Read response
	output logic             s_axi_rvalid,    // Read data valid
	input  wire logic        s_axi_rready,    // Read data ready
	output logic             displayEnable,   // Low: outputs low, bias off
	output logic             cursorShow,      // Cursor underline active
	output logic             cursorBlink,     // Cursor character blink
	output logic             columnMirror,    // Columns 60 down to 1
	output logic             rowMirror,       // Rows 16 to 1, icon swap
	output logic             splitMirror,     // Second half mirrored
	output logic             iconOnly,        // Icon rows only
	output logic             iconFlash        // Icon blinking enabled
);

	// ==========================================================
	// Configuration and execution state
	lie_state_t  state_q;
	logic [7:0]  cycCnt_q;
	logic [6:0]  addressCounter_q;
	logic [6:0]  clearAddr_q;
	logic [6:0]  dispShift_q;
	logic        busWidthSelect_q;
	logic        twoLine_q;
	logic        extSet_q;
	logic        incDir_q;
	logic        entryShift_q;
	logic        dispOn_q;
	logic        curOn_q;
	logic        blinkOn_q;
	logic        splitL_q;
	logic        colP_q;
	logic        rowQ_q;
	logic        iconOnlySelect_q;
	logic        iconFlashEnable_q;
	logic [7:0]  readDataBuffer_q;
	logic        nibbleHalf_q;
	logic [3:0]  nibbleHi_q;
	logic [7:0]  textRam [0:`LIE_TEXT_DEPTH-1];
	logic [7:0]  patternRam [0:63];

	// Axi bookkeeping
	logic        awHeld_q;
	logic        wHeld_q;
	logic [4:0]  awAddr_q;
	logic [31:0] wData_q;
	logic        wStrb_q;

	function automatic logic [6:0] stepAddr(input logic [6:0] a,
		input logic up);
		stepAddr = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
	endfunction

	// Pattern RAM selected by the most recent set-address command
	logic        patternSel_q;

	wire logic busy = state_q != LIE_IDLE;
	wire logic doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
	wire logic [7:0] wByte = wData_q[7:0];
	// A four-bit bus needs two writes before the byte is complete
	wire logic byteDone = busWidthSelect_q || nibbleHalf_q;
	wire logic [7:0] fullByte = busWidthSelect_q ? wByte
		: {nibbleHi_q, wData_q[7:4]};
	// A write whose low byte lane is masked carries no instruction
	wire logic isCmd = doWrite && awAddr_q == `LIE_OFF_CMD && wStrb_q;
	wire logic isDat = doWrite && awAddr_q == `LIE_OFF_DATA && wStrb_q;
	wire logic accept = (isCmd || isDat) && byteDone && !busy;
	wire logic doRead = s_axi_arvalid && s_axi_arready;
	wire logic rdData = doRead && s_axi_araddr == `LIE_OFF_DATA
		&& !busy;

	// ==========================================================
	// AXI write channel
	always_ff @(posedge clk) begin
		if (reset) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= 5'h00;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LIE_AXI_OKAY;
		end else if (clkEn) begin
			s_axi_awready <= !awHeld_q && !s_axi_awready;
			s_axi_wready <= !wHeld_q && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awAddr_q == `LIE_OFF_CMD
					|| awAddr_q == `LIE_OFF_DATA
					|| awAddr_q == `LIE_OFF_STATUS
					|| awAddr_q == `LIE_OFF_CONFIG
					|| awAddr_q == `LIE_OFF_RDBUF)
					? `LIE_AXI_OKAY : `LIE_AXI_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
			end
		end
	end

	// Nibble pairing, upper half first; writes while busy still toggle the half
	always_ff @(posedge clk) begin
		if (reset) begin
			nibbleHalf_q <= 1'b0;
			nibbleHi_q <= 4'h0;
		end else if (clkEn && (isCmd || isDat)
			&& !busWidthSelect_q) begin
			nibbleHalf_q <= !nibbleHalf_q;
			if (!nibbleHalf_q) begin
				nibbleHi_q <= wData_q[7:4];
			end
		end
	end

	// ==========================================================
	// AXI read channel
	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `LIE_AXI_OKAY;
		end else if (clkEn) begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (doRead) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `LIE_AXI_OKAY;
				case (s_axi_araddr)
					`LIE_OFF_STATUS: begin
						s_axi_rdata <= {24'h000000, busy,
							addressCounter_q};
					end
					`LIE_OFF_DATA: begin
						s_axi_rdata <= {24'h000000,
							readDataBuffer_q};
					end
					`LIE_OFF_CONFIG: begin
						s_axi_rdata <= {18'h00000, iconFlashEnable_q,
							iconOnlySelect_q, rowQ_q, colP_q, splitL_q,
							blinkOn_q, curOn_q, dispOn_q, entryShift_q,
							incDir_q, extSet_q, twoLine_q,
							busWidthSelect_q, patternSel_q};
					end
					`LIE_OFF_RDBUF: begin
						s_axi_rdata <= {25'h0000000, dispShift_q};
					end
					`LIE_OFF_CMD: begin
						s_axi_rdata <= 32'h0000_0000;
					end
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `LIE_AXI_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Busy timing
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= LIE_CLEAR;
			cycCnt_q <= `LIE_CYC_CLEAR;
		end else if (clkEn) begin
			case (state_q)
				LIE_IDLE: begin
					if (accept) begin
						cycCnt_q <= `LIE_CYC_STD - 8'd1;
						state_q <= LIE_BUSY;
						if (isCmd && !extSet_q
							&& fullByte == 8'h01) begin
							cycCnt_q <= `LIE_CYC_CLEAR - 8'd1;
							state_q <= LIE_CLEAR;
						end
					end else if (rdData) begin
						cycCnt_q <= `LIE_CYC_STD - 8'd1;
						state_q <= LIE_BUSY;
					end
				end
				LIE_BUSY, LIE_CLEAR: begin
					cycCnt_q <= 8'(cycCnt_q - 8'd1);
					if (cycCnt_q == 8'd1) begin
						state_q <= LIE_IDLE;
					end
				end
				default: begin
					state_q <= LIE_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Display RAM; clear sweeps one location per cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			clearAddr_q <= 7'h00;
		end else if (clkEn) begin
			if (state_q == LIE_CLEAR) begin
				textRam[clearAddr_q] <= `LIE_BLANK_CODE;
				clearAddr_q <= 7'(clearAddr_q + 7'h01);
			end else begin
				clearAddr_q <= 7'h00;
				if (accept && isDat && !patternSel_q) begin
					textRam[addressCounter_q] <= fullByte;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (clkEn && accept && isDat && patternSel_q) begin
			patternRam[addressCounter_q[5:0]] <= fullByte;
		end
	end

	// ==========================================================
	// Instruction execution
	always_ff @(posedge clk) begin
		if (reset) begin
			addressCounter_q <= 7'h00;
			dispShift_q <= 7'h00;
			busWidthSelect_q <= 1'b1;
			twoLine_q <= 1'b0;
			extSet_q <= 1'b0;
			incDir_q <= 1'b1;
			entryShift_q <= 1'b0;
			dispOn_q <= 1'b0;
			curOn_q <= 1'b0;
			blinkOn_q <= 1'b0;
			splitL_q <= 1'b0;
			colP_q <= 1'b0;
			rowQ_q <= 1'b0;
			iconOnlySelect_q <= 1'b0;
			iconFlashEnable_q <= 1'b0;
			patternSel_q <= 1'b0;
			readDataBuffer_q <= 8'h00;
		end else if (clkEn) begin
			if (rdData) begin
				addressCounter_q <= stepAddr(addressCounter_q,
					incDir_q);
				readDataBuffer_q <= patternSel_q
					? patternRam[6'(stepAddr(addressCounter_q,
						incDir_q))]
					: textRam[stepAddr(addressCounter_q,
						incDir_q)];
			end else if (accept && isDat) begin
				addressCounter_q <= stepAddr(addressCounter_q,
					incDir_q);
				if (entryShift_q && !patternSel_q) begin
					dispShift_q <= incDir_q
						? 7'(dispShift_q - 7'h01)
						: 7'(dispShift_q + 7'h01);
				end
			end else if (accept && isCmd) begin
				// Commands run even with the display off
				if (fullByte[7] && !extSet_q) begin
					addressCounter_q <= fullByte[6:0];
					patternSel_q <= 1'b0;
					readDataBuffer_q <= textRam[fullByte[6:0]];
				end else if (fullByte[7:5] == 3'b001) begin
					busWidthSelect_q <= fullByte[4];
					twoLine_q <= fullByte[2];
					extSet_q <= fullByte[0];
				end else if (!extSet_q) begin
					if (fullByte[7:6] == 2'b01) begin
						addressCounter_q <= {addressCounter_q[6],
							fullByte[5:0]};
						patternSel_q <= 1'b1;
						readDataBuffer_q <= patternRam[fullByte[5:0]];
					end else if (fullByte[7:4] == 4'b0001) begin
						if (fullByte[3]) begin
							dispShift_q <= fullByte[2]
								? 7'(dispShift_q + 7'h01)
								: 7'(dispShift_q - 7'h01);
						end else begin
							addressCounter_q <= stepAddr(
								addressCounter_q, fullByte[2]);
						end
					end else if (fullByte[7:3] == 5'b00001) begin
						dispOn_q <= fullByte[2];
						curOn_q <= fullByte[1];
						blinkOn_q <= fullByte[0];
					end else if (fullByte[7:2] == 6'b000001) begin
						incDir_q <= fullByte[1];
						entryShift_q <= fullByte[0];
					end else if (fullByte[7:1] == 7'b0000001) begin
						addressCounter_q <= 7'h00;
						dispShift_q <= 7'h00;
					end else if (fullByte == 8'h01) begin
						addressCounter_q <= 7'h00;
						dispShift_q <= 7'h00;
						incDir_q <= 1'b1;
					end
				end else begin
					// Codes outside the list leave all state alone
					if (fullByte[7:3] == 5'b00001
						&& !fullByte[0]) begin
						iconOnlySelect_q <= fullByte[2];
						iconFlashEnable_q <= fullByte[1];
					end else if (fullByte[7:2] == 6'b000001) begin
						colP_q <= fullByte[1];
						rowQ_q <= fullByte[0];
					end else if (fullByte[7:1] == 7'b0000001) begin
						splitL_q <= fullByte[0];
					end
				end
			end
		end
	end

	// ==========================================================
	// Registered display controls
	always_ff @(posedge clk) begin
		if (reset) begin
			displayEnable <= 1'b0;
			cursorShow <= 1'b0;
			cursorBlink <= 1'b0;
			columnMirror <= 1'b0;
			rowMirror <= 1'b0;
			splitMirror <= 1'b0;
			iconOnly <= 1'b0;
			iconFlash <= 1'b0;
		end else if (clkEn) begin
			displayEnable <= dispOn_q;
			cursorShow <= curOn_q && !patternSel_q;
			cursorBlink <= blinkOn_q && !patternSel_q;
			columnMirror <= colP_q;
			rowMirror <= rowQ_q;
			splitMirror <= splitL_q && !twoLine_q;
			iconOnly <= iconOnlySelect_q;
			iconFlash <= iconFlashEnable_q;
		end
	end

	// ==========================================================
	// Checks
	property p_busyLen;
		@(posedge clk) disable iff (reset)
		(clkEn && state_q == LIE_IDLE && accept && isCmd
			&& fullByte == 8'h02 && !extSet_q) ##1 clkEn
		|=> busy;
	endproperty
	a_busyLen: assert property (p_busyLen)
		else $error("busy dropped early");

	property p_cursorOff;
		@(posedge clk) disable iff (reset)
		(clkEn && patternSel_q) |=> !cursorShow;
	endproperty
	a_cursorOff: assert property (p_cursorOff)
		else $error("cursor shown in pattern RAM");

	property p_noChangeBusy;
		@(posedge clk) disable iff (reset)
		(clkEn && busy && !rdData) |=> $stable(incDir_q)
			|| state_q == LIE_IDLE;
	endproperty
	a_noChangeBusy: assert property (p_noChangeBusy)
		else $error("state changed while busy");

	property p_split;
		@(posedge clk) disable iff (reset)
		(clkEn && twoLine_q) |=> !splitMirror;
	endproperty
	a_split: assert property (p_split)
		else $error("split mirror in two-line mode");

	property p_discard;
		@(posedge clk) disable iff (reset)
		(clkEn && busy) |=> $stable(addressCounter_q);
	endproperty
	a_discard: assert property (p_discard)
		else $error("counter moved while busy");

	property p_homeZero;
		@(posedge clk) disable iff (reset)
		(clkEn && accept && isCmd && !extSet_q && fullByte == 8'h02)
		|=> addressCounter_q == 7'h00;
	endproperty
	a_homeZero: assert property (p_homeZero)
		else $error("home left counter nonzero");

	property p_freeze;
		@(posedge clk) disable iff (reset)
		(!clkEn) |=> $stable(state_q) && $stable(cycCnt_q);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("busy timing moved with oscillator stopped");

endmodule
`default_nettype wire

// ===== test/lie_executor_tb_top.sv
// Self-checking bench for the instruction executor
`timescale 1ns/1ps
`default_nettype none
`include "lie_defs.svh"
module lie_executor_tb_top;
	logic        clk = 1'b0;
	logic        reset;
	logic        clkEn;
	logic [4:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready;
	logic        dispEn, curShow, curBlink, colMir;
	logic        rowMir, splitMir, iconOn, iconFl;
	wire logic [7:0] outs = {dispEn, curShow, curBlink, colMir,
		rowMir, splitMir, iconOn, iconFl};
	logic [7:0]  d [4];
	logic [7:0]  sc [4] = '{8'h14, 8'h10, 8'h18, 8'h1c};
	logic [6:0]  se [4] = '{7'h06, 7'h05, 7'h05, 7'h05};
	int          n_errors = 0;
	int          tests_run = 0;

	always #50 clk = ~clk;

	lie_executor DUT (
		.clk(clk), .reset(reset), .clkEn(clkEn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.displayEnable(dispEn), .cursorShow(curShow),
		.cursorBlink(curBlink), .columnMirror(colMir),
		.rowMirror(rowMir), .splitMirror(splitMir),
		.iconOnly(iconOn), .iconFlash(iconFl)
	);

	lie_host_model host (
		.clk(clk), .clkEn(clkEn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready)
	);

	// ==========
	// Checking
	task automatic check(input string n, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("Checks %0d, errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic stat(input string n, input logic [7:0] e);
		host.rd(`LIE_OFF_STATUS, v, r);
		check(n, v, {24'h0, e});
	endtask

	task automatic cfg(input string n, input logic [31:0] m,
		input logic [31:0] e);
		host.rd(`LIE_OFF_CONFIG, v, r);
		check(n, v & m, e);
	endtask

	// Reserved extended codes, one class per k
	function automatic logic [7:0] resv(input int k, input logic [7:0] x);
		case (k)
			0: return 8'h01;
			1: return {4'h1, x[3:0]};
			2: return {2'b01, x[5:0]};
			default: return {1'b1, x[6:0]};
		endcase
	endfunction

	// c holds split, column, row, icon only, icon flash
	function automatic logic [4:0] mir(input logic [4:0] c, input logic m);
		return {c[3], c[2], c[4] & ~m, c[1], c[0]};
	endfunction

	initial begin
		#5_000_000;
		n_errors++;
		summarize();
	end

	// ==========
	// Scenarios
	initial begin
		logic [6:0] a;
		logic [4:0] c;
		logic       m;
		logic [7:0] b;
		reset = 1'b1;
		void'($urandom(40));
		repeat (4) @(posedge clk);
		check("outputs in reset", 32'(outs), 32'h0);
		reset <= 1'b0;
		@(posedge clk);
		host.rd(`LIE_OFF_STATUS, v, r);
		check("busy after reset", 32'(v[7]), 32'h1);
		host.poll();
		host.wr(5'h14, 32'h0, r);
		check("unmapped write", 32'(r), 32'(`LIE_AXI_SLVERR));
		host.rd(5'h14, v, r);
		check("unmapped read", 32'(r), 32'(`LIE_AXI_SLVERR));
		host.wr(`LIE_OFF_CMD, 32'h01, r);
		host.wr(`LIE_OFF_CMD, 32'h85, r);
		check("write while busy", 32'(r), 32'(`LIE_AXI_OKAY));
		host.rd(`LIE_OFF_STATUS, v, r);
		check("status while busy", 32'(v[7]), 32'h1);
		host.poll();
		stat("clear counter", 8'h00);
		cfg("clear direction", 32'h10, 32'h10);
		a = 7'h10 + 7'($urandom_range(15));
		host.cmd({1'b1, a});
		for (int i = 0; i < 4; i++) begin
			d[i] = 8'($urandom);
			host.dat(d[i]);
		end
		stat("after writes", {1'b0, a + 7'h4});
		host.cmd(8'h04);
		host.dat(8'h5a);
		stat("after down write", {1'b0, a + 7'h3});
		host.cmd({1'b1, a});
		host.rdat(b);
		check("first read", 32'(b), 32'(d[0]));
		stat("after read", {1'b0, a - 7'h1});
		host.rdat(b);
		check("blank read", 32'(b), 32'(`LIE_BLANK_CODE));
		host.cmd(8'h02);
		stat("home", 8'h00);
		cfg("home keeps direction", 32'h10, 32'h0);
		host.cmd({1'b1, a + 7'h1});
		host.rdat(b);
		check("kept byte", 32'(b), 32'(d[1]));
		host.strb = 4'he;
		host.wr(`LIE_OFF_CMD, 32'h01, r);
		host.strb = 4'hf;
		stat("masked clear ignored", {1'b0, a});
		host.cmd(8'h0f);
		check("display on", 32'(outs[7:5]), 32'h7);
		host.cmd(8'hc5);
		host.cmd(8'h4a);
		stat("pattern keeps bit 6", 8'h4a);
		check("cursor in pattern", 32'(outs[6:5]), 32'h0);
		host.cmd(8'h85);
		host.cmd(8'h4a);
		stat("pattern low bits", 8'h0a);
		host.cmd(8'h85);
		check("cursor back", 32'(outs[6:5]), 32'h3);
		for (int i = 0; i < 4; i++) begin
			host.cmd(sc[i]);
			stat("shift", {1'b0, se[i]});
		end
		host.cmd(8'h07);
		host.dat(8'h41);
		host.rd(`LIE_OFF_RDBUF, v, r);
		check("shift on text write", v, 32'h7f);
		host.cmd(8'h85);
		for (int i = 0; i < 12; i++) begin
			m = 1'($urandom);
			c = 5'($urandom);
			host.cmd({5'b00110, m, 2'b01});
			cfg("function set", 32'he, {28'h0, 1'b1, m, 2'b10});
			host.cmd({7'h01, c[4]});
			host.cmd({6'h01, c[3:2]});
			host.cmd({5'h01, c[1:0], 1'b0});
			host.cmd(resv(i % 4, 8'($urandom)));
			host.cmd(8'h00);
			check("mirror", 32'(outs[4:0]), 32'(mir(c, m)));
			stat("reserved", 8'h05);
		end
		host.cmd(8'h20);
		host.cmd(8'h30);
		host.wr(`LIE_OFF_CMD, 32'h40, r);
		host.poll();
		cfg("nibble function set", 32'he, 32'h6);
		host.cmd(8'h08);
		check("display off", 32'(outs[7]), 32'h0);
		host.cmd(8'h87);
		stat("runs while off", 8'h07);
		host.nap();
		host.cmd(8'h0c);
		check("display back", 32'(outs[7:5]), 32'h4);
		summarize();
	end
endmodule
`default_nettype wire

// ===== test/lie_host_model.sv
// Host model: AXI4-Lite master that sends display instructions
`timescale 1ns/1ps
`default_nettype none
`include "lie_defs.svh"
module lie_host_model (
	input  wire logic        clk,           // System clock
	output logic             clkEn,         // Oscillator run
	output logic [4:0]       s_axi_awaddr,  // Write address
	output logic             s_axi_awvalid, // Address valid
	input  wire logic        s_axi_awready, // Address ready
	output logic [31:0]      s_axi_wdata,   // Write data
	output logic [3:0]       s_axi_wstrb,   // Byte strobes
	output logic             s_axi_wvalid,  // Data valid
	input  wire logic        s_axi_wready,  // Data ready
	input  wire logic [1:0]  s_axi_bresp,   // Write response
	input  wire logic        s_axi_bvalid,  // Response valid
	output logic             s_axi_bready,  // Response ready
	output logic [4:0]       s_axi_araddr,  // Read address
	output logic             s_axi_arvalid, // Address valid
	input  wire logic        s_axi_arready, // Address ready
	input  wire logic [31:0] s_axi_rdata,   // Read data
	input  wire logic [1:0]  s_axi_rresp,   // Read response
	input  wire logic        s_axi_rvalid,  // Read valid
	output logic             s_axi_rready   // Read ready
);
	logic [3:0] strb = 4'hf; // Lanes offered by the next write

	initial begin
		clkEn = 1'b1;
		s_axi_wstrb = 4'hf;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end

	// ==========
	// Bus cycles
	task automatic wr(input logic [4:0] a, input logic [31:0] d,
		output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= strb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid && !s_axi_awready ||
			s_axi_wvalid && !s_axi_wready);
		do @(posedge clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] d,
		output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask

	// ==========
	// Instructions
	task automatic poll();
		logic [31:0] s;
		logic [1:0]  r;
		do rd(`LIE_OFF_STATUS, s, r); while (s[7] !== 1'b0);
	endtask

	task automatic put(input logic [4:0] a, input logic [7:0] b);
		logic [1:0] r;
		poll();
		wr(a, {24'h0, b}, r);
		poll();
	endtask

	task automatic cmd(input logic [7:0] b);
		put(`LIE_OFF_CMD, b);
	endtask

	task automatic dat(input logic [7:0] b);
		put(`LIE_OFF_DATA, b);
	endtask

	task automatic rdat(output logic [7:0] b);
		logic [31:0] v;
		logic [1:0]  r;
		poll();
		rd(`LIE_OFF_DATA, v, r);
		b = v[7:0];
		poll();
	endtask

	// Outputs fall one cycle after their state; three cycles pass before the oscillator stops
	task automatic nap();
		repeat (3) @(posedge clk);
		clkEn <= 1'b0;
		repeat (20) @(posedge clk);
		clkEn <= 1'b1;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire
